// file: mir_pkg.sv
// Register map constants for the meter interval register bank.
// Assumes a 16-bit register word port driven by a Modbus framing block.
package mir_pkg;
   localparam logic [15:0] ADDR_CLK_HM = 16'h0036;
   localparam logic [15:0] ADDR_CLK_SEC = 16'h0037;
   localparam logic [15:0] ADDR_CLK_MD = 16'h0038;
   localparam logic [15:0] ADDR_CLK_YEAR = 16'h0039;
   localparam logic [15:0] ADDR_OLD_HM = 16'h003a;
   localparam logic [15:0] ADDR_OLD_MD = 16'h003b;
   localparam logic [15:0] ADDR_OLD_YEAR = 16'h003c;
   localparam logic [15:0] ADDR_NEW_HM = 16'h003d;
   localparam logic [15:0] ADDR_NEW_MD = 16'h003e;
   localparam logic [15:0] ADDR_NEW_YEAR = 16'h003f;
   localparam logic [15:0] ADDR_SEL_HM = 16'h0040;
   localparam logic [15:0] ADDR_SEL_MD = 16'h0041;
   localparam logic [15:0] ADDR_SEL_YEAR = 16'h0042;
   localparam logic [15:0] ADDR_HANDSHAKE = 16'h0043;
   localparam logic [15:0] ADDR_VALIDITY = 16'h0063;
   localparam logic [15:0] ADDR_REAL = 16'h0064;
   localparam logic [15:0] ADDR_REACTIVE = 16'h0066;
   localparam logic [15:0] ADDR_APPARENT = 16'h0068;
   localparam logic [15:0] ADDR_PF = 16'h006a;
   localparam logic [15:0] ADDR_FREQ_A = 16'h0162;
   localparam logic [15:0] ADDR_VOLT_AN = 16'h016a;
   localparam logic [15:0] ADDR_VOLT_BN = 16'h016c;
   localparam logic [15:0] ADDR_VOLT_CN = 16'h016e;
   // Packed time and date field positions
   localparam int HI_MSB = 15;
   localparam int HI_LSB = 8;
   localparam int LO_MSB = 7;
   localparam int LO_LSB = 0;
   localparam int IGNORED_BIT = 15;
   // Handshake and qualifying-register codes
   localparam logic [15:0] HS_READY = 16'h0000;
   localparam logic [15:0] HS_LOAD = 16'h0001;
   localparam logic [15:0] HS_INVALID = 16'h0002;
   localparam logic [15:0] QUAL_INVALID = 16'h0008;
   localparam logic [15:0] QUAL_VALID = 16'h0000;
   // Reset values
   localparam logic [15:0] RST_HM = 16'h0000;
   localparam logic [15:0] RST_SEC = 16'h0000;
   localparam logic [15:0] RST_MD = 16'h0101;
   localparam logic [15:0] RST_YEAR = 16'h0000;
   localparam logic [31:0] RST_FLOAT = 32'h0000_0000;
endpackage : mir_pkg

// file: mir_ts_check.sv
// Checks a packed timestamp for field ranges.
// Assumes words laid out as in mir_pkg; purely combinational.
`timescale 1ns/1ps
module mir_ts_check (
   input wire logic [15:0] hours_minutes,
   input wire logic [15:0] month_day,
   output logic ts_ok
);
   wire [7:0] hour = hours_minutes[mir_pkg::HI_MSB:mir_pkg::HI_LSB];
   wire [7:0] minute = hours_minutes[mir_pkg::LO_MSB:mir_pkg::LO_LSB];
   wire [7:0] month = month_day[mir_pkg::HI_MSB:mir_pkg::HI_LSB];
   wire [7:0] day = month_day[mir_pkg::LO_MSB:mir_pkg::LO_LSB];
   wire time_ok = (hour <= 8'h17) && (minute <= 8'h3b);
   wire date_ok = (month >= 8'h01) && (month <= 8'h0c)
      && (day >= 8'h01) && (day <= 8'h1f);
   assign ts_ok = time_ok && date_ok;
endmodule : mir_ts_check

// file: mir_ts_cmp.sv
// Compares two timestamps (year, month/day, hours/minutes) in order.
// Assumes packed words; combinational, less-or-equal result.
`timescale 1ns/1ps
module mir_ts_cmp (
   input wire logic [15:0] a_year,
   input wire logic [15:0] a_md,
   input wire logic [15:0] a_hm,
   input wire logic [15:0] b_year,
   input wire logic [15:0] b_md,
   input wire logic [15:0] b_hm,
   output logic a_le_b
);
   // Packing puts higher-order fields in higher bits, so one compare works
   wire [47:0] a_key = {a_year, a_md, a_hm};
   wire [47:0] b_key = {b_year, b_md, b_hm};
   assign a_le_b = a_key <= b_key;
endmodule : mir_ts_cmp

// file: mir_regs.sv
// Holding-register bank for stored interval access and the meter clock.
// Assumes a framing block issuing single-word reads and writes on clock,
// and a storage engine that answers interval loads with a fetch handshake.
//
// Contract
// - Hours/minutes words: hour 0-23 upper byte, minute 0-59 lower byte.
// - Month/day words: month 1-12 upper byte, day 1-31 lower byte.
// - Year registers hold a plain unsigned 16-bit year.
// - Seconds of internal time has its own read/write register.
// - Oldest stored interval timestamp in three packed registers.
// - Newest stored interval timestamp in three registers, same layout.
// - Handshake bit 15 is ignored by master; state in remaining bits.
// - Write 1 requests load; device answers 0 ready or 2 invalid.
// - Qualifying register read-only; value 8 marks invalid interval.
// - Stored kW, kvar, kVA, PF totals read-only, two registers apart.
// - Stored interval registers hold stored data, not live values.
// - Two-register values are IEEE 754 single precision floats.
`timescale 1ns/1ps
module mir_regs (
   input wire logic clock,
   input wire logic sys_rst,
   // Register word port
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   output logic [15:0] reg_rdata,
   output logic reg_hit,
   // Clock tick and oldest/newest updates from the recorder
   input wire logic clock_load,
   input wire logic [15:0] clock_hm_in,
   input wire logic [15:0] clock_sec_in,
   input wire logic [15:0] clock_md_in,
   input wire logic [15:0] clock_year_in,
   input wire logic range_load,
   input wire logic [15:0] oldest_hm_in,
   input wire logic [15:0] oldest_md_in,
   input wire logic [15:0] oldest_year_in,
   input wire logic [15:0] newest_hm_in,
   input wire logic [15:0] newest_md_in,
   input wire logic [15:0] newest_year_in,
   // Stored interval fetch handshake
   output logic fetch_req,
   output logic [15:0] fetch_hm,
   output logic [15:0] fetch_md,
   output logic [15:0] fetch_year,
   input wire logic fetch_done,
   input wire logic fetch_found,
   input wire logic [15:0] fetch_quality,
   input wire logic [31:0] fetch_real,
   input wire logic [31:0] fetch_reactive,
   input wire logic [31:0] fetch_apparent,
   input wire logic [31:0] fetch_pf,
   // Live floats from the metering front end
   input wire logic [31:0] live_freq_a,
   input wire logic [31:0] live_volt_an,
   input wire logic [31:0] live_volt_bn,
   input wire logic [31:0] live_volt_cn
);
   typedef enum logic [2:0] {
      MIR_IDLE = 3'b001,
      MIR_FETCH = 3'b010,
      MIR_CHECK = 3'b100
   } mir_state_t;

   mir_state_t state;
   mir_state_t next_state;

   logic [15:0] clk_hm, clk_sec, clk_md, clk_year;
   logic [15:0] old_hm, old_md, old_year;
   logic [15:0] new_hm, new_md, new_year;
   logic [15:0] sel_hm, sel_md, sel_year;
   logic [14:0] handshake;
   logic [15:0] quality;
   logic [31:0] st_real, st_reactive, st_apparent, st_pf;

   // Upper word at the even address, lower at the odd one
   function automatic logic [15:0] float_half(input logic [31:0] value,
                                              input logic low_half);
      float_half = low_half ? value[15:0] : value[31:16];
   endfunction : float_half

   function automatic logic is_pair(input logic [15:0] addr,
                                    input logic [15:0] base);
      is_pair = (addr[15:1] == base[15:1]);
   endfunction : is_pair

   wire sel_ok;
   wire after_oldest;
   wire before_newest;

   mir_ts_check u_check (
      .hours_minutes(sel_hm),
      .month_day(sel_md),
      .ts_ok(sel_ok)
   );

   mir_ts_cmp u_cmp (
      .a_year(old_year),
      .a_md(old_md),
      .a_hm(old_hm),
      .b_year(sel_year),
      .b_md(sel_md),
      .b_hm(sel_hm),
      .a_le_b(after_oldest)
   );

   mir_ts_cmp u_cmp_new (
      .a_year(sel_year),
      .a_md(sel_md),
      .a_hm(sel_hm),
      .b_year(new_year),
      .b_md(new_md),
      .b_hm(new_hm),
      .a_le_b(before_newest)
   );

   wire busy = (state != MIR_IDLE);
   wire wr_clk_hm = reg_wr && (reg_addr == mir_pkg::ADDR_CLK_HM);
   wire wr_clk_sec = reg_wr && (reg_addr == mir_pkg::ADDR_CLK_SEC);
   wire wr_clk_md = reg_wr && (reg_addr == mir_pkg::ADDR_CLK_MD);
   wire wr_clk_year = reg_wr && (reg_addr == mir_pkg::ADDR_CLK_YEAR);
   wire wr_old_hm = reg_wr && (reg_addr == mir_pkg::ADDR_OLD_HM);
   wire wr_old_md = reg_wr && (reg_addr == mir_pkg::ADDR_OLD_MD);
   wire wr_old_year = reg_wr && (reg_addr == mir_pkg::ADDR_OLD_YEAR);
   wire wr_new_hm = reg_wr && (reg_addr == mir_pkg::ADDR_NEW_HM);
   wire wr_new_md = reg_wr && (reg_addr == mir_pkg::ADDR_NEW_MD);
   wire wr_new_year = reg_wr && (reg_addr == mir_pkg::ADDR_NEW_YEAR);
   // Selection frozen during a load so the fetched key stays consistent
   wire wr_sel_hm = reg_wr && !busy
      && (reg_addr == mir_pkg::ADDR_SEL_HM);
   wire wr_sel_md = reg_wr && !busy
      && (reg_addr == mir_pkg::ADDR_SEL_MD);
   wire wr_sel_year = reg_wr && !busy
      && (reg_addr == mir_pkg::ADDR_SEL_YEAR);
   wire wr_hs = reg_wr && (reg_addr == mir_pkg::ADDR_HANDSHAKE);
   // Bit 15 of the written value is not part of the code
   wire load_cmd = wr_hs && !busy
      && (reg_wdata[14:0] == mir_pkg::HS_LOAD[14:0]);
   wire ts_valid = sel_ok && after_oldest && before_newest;

   always_comb begin
      next_state = state;
      case (state)
         MIR_IDLE: begin
            if (load_cmd) begin
               next_state = MIR_CHECK;
            end
         end
         MIR_CHECK: begin
            next_state = ts_valid ? MIR_FETCH : MIR_IDLE;
         end
         MIR_FETCH: begin
            if (fetch_done) begin
               next_state = MIR_IDLE;
            end
         end
         default: begin
            next_state = MIR_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         state <= MIR_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // Clock registers: a master write wins over the running clock update
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         clk_hm <= mir_pkg::RST_HM;
         clk_sec <= mir_pkg::RST_SEC;
         clk_md <= mir_pkg::RST_MD;
         clk_year <= mir_pkg::RST_YEAR;
      end else begin
         clk_hm <= wr_clk_hm ? reg_wdata
            : (clock_load ? clock_hm_in : clk_hm);
         clk_sec <= wr_clk_sec ? reg_wdata
            : (clock_load ? clock_sec_in : clk_sec);
         clk_md <= wr_clk_md ? reg_wdata
            : (clock_load ? clock_md_in : clk_md);
         clk_year <= wr_clk_year ? reg_wdata
            : (clock_load ? clock_year_in : clk_year);
      end
   end

   // Recorder updates win: they reflect what is actually stored
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         old_hm <= mir_pkg::RST_HM;
         old_md <= mir_pkg::RST_MD;
         old_year <= mir_pkg::RST_YEAR;
         new_hm <= mir_pkg::RST_HM;
         new_md <= mir_pkg::RST_MD;
         new_year <= mir_pkg::RST_YEAR;
      end else if (range_load) begin
         old_hm <= oldest_hm_in;
         old_md <= oldest_md_in;
         old_year <= oldest_year_in;
         new_hm <= newest_hm_in;
         new_md <= newest_md_in;
         new_year <= newest_year_in;
      end else begin
         old_hm <= wr_old_hm ? reg_wdata : old_hm;
         old_md <= wr_old_md ? reg_wdata : old_md;
         old_year <= wr_old_year ? reg_wdata : old_year;
         new_hm <= wr_new_hm ? reg_wdata : new_hm;
         new_md <= wr_new_md ? reg_wdata : new_md;
         new_year <= wr_new_year ? reg_wdata : new_year;
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         sel_hm <= mir_pkg::RST_HM;
         sel_md <= mir_pkg::RST_MD;
         sel_year <= mir_pkg::RST_YEAR;
      end else begin
         sel_hm <= wr_sel_hm ? reg_wdata : sel_hm;
         sel_md <= wr_sel_md ? reg_wdata : sel_md;
         sel_year <= wr_sel_year ? reg_wdata : sel_year;
      end
   end

   // Handshake: hardware owns it while busy; other idle writes ignored
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         handshake <= mir_pkg::HS_READY[14:0];
      end else if (load_cmd) begin
         handshake <= mir_pkg::HS_LOAD[14:0];
      end else if (state == MIR_CHECK && !ts_valid) begin
         handshake <= mir_pkg::HS_INVALID[14:0];
      end else if (state == MIR_FETCH && fetch_done) begin
         handshake <= fetch_found ? mir_pkg::HS_READY[14:0]
            : mir_pkg::HS_INVALID[14:0];
      end
   end

   // Stored values change only on a completed fetch
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         quality <= mir_pkg::QUAL_INVALID;
         st_real <= mir_pkg::RST_FLOAT;
         st_reactive <= mir_pkg::RST_FLOAT;
         st_apparent <= mir_pkg::RST_FLOAT;
         st_pf <= mir_pkg::RST_FLOAT;
      end else if (state == MIR_FETCH && fetch_done) begin
         quality <= fetch_found ? fetch_quality
            : mir_pkg::QUAL_INVALID;
         st_real <= fetch_found ? fetch_real : st_real;
         st_reactive <= fetch_found ? fetch_reactive : st_reactive;
         st_apparent <= fetch_found ? fetch_apparent : st_apparent;
         st_pf <= fetch_found ? fetch_pf : st_pf;
      end
   end

   assign fetch_req = (state == MIR_FETCH);
   assign fetch_hm = sel_hm;
   assign fetch_md = sel_md;
   assign fetch_year = sel_year;

   // Read-only words decode for reads only, so writes there do nothing
   wire lo = reg_addr[0];
   logic [15:0] next_rdata;
   logic next_hit;
   always_comb begin
      next_hit = 1'b1;
      next_rdata = 16'h0000;
      case (reg_addr)
         mir_pkg::ADDR_CLK_HM: next_rdata = clk_hm;
         mir_pkg::ADDR_CLK_SEC: next_rdata = clk_sec;
         mir_pkg::ADDR_CLK_MD: next_rdata = clk_md;
         mir_pkg::ADDR_CLK_YEAR: next_rdata = clk_year;
         mir_pkg::ADDR_OLD_HM: next_rdata = old_hm;
         mir_pkg::ADDR_OLD_MD: next_rdata = old_md;
         mir_pkg::ADDR_OLD_YEAR: next_rdata = old_year;
         mir_pkg::ADDR_NEW_HM: next_rdata = new_hm;
         mir_pkg::ADDR_NEW_MD: next_rdata = new_md;
         mir_pkg::ADDR_NEW_YEAR: next_rdata = new_year;
         mir_pkg::ADDR_SEL_HM: next_rdata = sel_hm;
         mir_pkg::ADDR_SEL_MD: next_rdata = sel_md;
         mir_pkg::ADDR_SEL_YEAR: next_rdata = sel_year;
         mir_pkg::ADDR_HANDSHAKE: next_rdata = {1'b0, handshake};
         mir_pkg::ADDR_VALIDITY: next_rdata = quality;
         default: begin
            if (is_pair(reg_addr, mir_pkg::ADDR_REAL)) begin
               next_rdata = float_half(st_real, lo);
            end else if (is_pair(reg_addr, mir_pkg::ADDR_REACTIVE)) begin
               next_rdata = float_half(st_reactive, lo);
            end else if (is_pair(reg_addr, mir_pkg::ADDR_APPARENT)) begin
               next_rdata = float_half(st_apparent, lo);
            end else if (is_pair(reg_addr, mir_pkg::ADDR_PF)) begin
               next_rdata = float_half(st_pf, lo);
            end else if (is_pair(reg_addr, mir_pkg::ADDR_FREQ_A)) begin
               next_rdata = float_half(live_freq_a, lo);
            end else if (is_pair(reg_addr, mir_pkg::ADDR_VOLT_AN)) begin
               next_rdata = float_half(live_volt_an, lo);
            end else if (is_pair(reg_addr, mir_pkg::ADDR_VOLT_BN)) begin
               next_rdata = float_half(live_volt_bn, lo);
            end else if (is_pair(reg_addr, mir_pkg::ADDR_VOLT_CN)) begin
               next_rdata = float_half(live_volt_cn, lo);
            end else begin
               next_hit = 1'b0;
            end
         end
      endcase
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         reg_rdata <= 16'h0000;
         reg_hit <= 1'b0;
      end else if (reg_rd) begin
         reg_rdata <= next_rdata;
         reg_hit <= next_hit;
      end
   end
endmodule : mir_regs

// file: mir_regs_asserts.sv
// Port-level assertions for the interval register bank.
// Assumes single-word strobes and a partner pulsing fetch_done once.
`timescale 1ns/1ps
module mir_regs_asserts (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic [15:0] reg_rdata,
   input wire logic reg_hit,
   input wire logic clock_load,
   input wire logic range_load,
   input wire logic fetch_req,
   input wire logic [15:0] fetch_hm,
   input wire logic [15:0] fetch_md,
   input wire logic [15:0] fetch_year,
   input wire logic fetch_done,
   input wire logic fetch_found,
   input wire logic [31:0] fetch_real,
   input wire logic [31:0] live_freq_a
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (sys_rst);
   // Gaps only; the float tails are not pinned down
   wire logic unmapped = reg_addr < 16'h0036 || reg_addr > 16'h016f ||
      (reg_addr > 16'h0043 && reg_addr < 16'h0063);
   wire logic quiet = !clock_load && !range_load && !fetch_req;
   wire logic flag_rd = reg_rd && reg_addr == mir_pkg::ADDR_HANDSHAKE;
   wire logic got_rec = fetch_req && fetch_done && fetch_found;
   wire logic load_wr = reg_wr && reg_addr == mir_pkg::ADDR_HANDSHAKE &&
      reg_wdata[14:0] == 15'h0001;
   property p_wr_rd(logic [15:0] a);
      reg_wr && reg_addr == a && quiet ##1 reg_rd && reg_addr == a && quiet
         |=> reg_rdata == $past(reg_wdata, 2);
   endproperty
   a_unmapped_zero:
   assert property (reg_rd && unmapped |=> !reg_hit && reg_rdata == 16'h0000)
      else $error("unmapped read returned data");
   a_mapped_hit:
   assert property (reg_rd && reg_addr inside {[16'h0036:16'h0043]} |=> reg_hit)
      else $error("mapped read not flagged");
   a_live_upper:
   assert property (reg_rd && reg_addr == mir_pkg::ADDR_FREQ_A |=>
      {reg_rdata, 16'h0000} == ($past(live_freq_a) & 32'hffff_0000))
      else $error("live frequency upper half wrong");
   a_fetch_start:
   assert property ($rose(fetch_req) |-> $past(load_wr, 2))
      else $error("fetch without load request");
   a_fetch_drop:
   assert property (fetch_req && fetch_done |=> !fetch_req)
      else $error("fetch request held after answer");
   a_fetch_stable:
   assert property (fetch_req ##1 fetch_req |->
      $stable({fetch_hm, fetch_md, fetch_year}))
      else $error("selected timestamp moved during fetch");
   a_busy_flag:
   assert property (flag_rd && fetch_req && !fetch_done |=>
      reg_rdata == mir_pkg::HS_LOAD) else $error("flag not busy");
   a_flag_bit15:
   assert property (flag_rd |=> !reg_rdata[15]) else $error("flag bit 15 set");
   a_sec_rw:
   assert property (p_wr_rd(mir_pkg::ADDR_CLK_SEC))
      else $error("seconds lost");
   a_year_rw:
   assert property (p_wr_rd(mir_pkg::ADDR_CLK_YEAR)) else $error("year lost");
   a_sel_rw:
   assert property (p_wr_rd(mir_pkg::ADDR_SEL_MD))
      else $error("selection lost");
   a_ready_code:
   assert property (got_rec ##1 flag_rd |=> reg_rdata == mir_pkg::HS_READY)
      else $error("flag not ready after record");
   a_stored_kw:
   assert property (got_rec ##3 reg_rd && reg_addr == mir_pkg::ADDR_REAL |=>
      {reg_rdata, 16'h0000} == ($past(fetch_real, 4) & 32'hffff_0000))
      else $error("stored real power not loaded");
   c_found_load: cover property (got_rec);
   c_not_found: cover property (fetch_req && fetch_done && !fetch_found);
   c_unmapped_read: cover property (reg_rd && unmapped);
endmodule : mir_regs_asserts

bind mir_regs mir_regs_asserts mir_regs_asserts_inst (
   .clock, .sys_rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
   .reg_hit, .clock_load, .range_load, .fetch_req, .fetch_hm, .fetch_md,
   .fetch_year, .fetch_done, .fetch_found, .fetch_real, .live_freq_a
);

// file: mir_store_model.sv
// Storage engine model answering interval fetches of the register bank.
// Assumes fetch_req holds until fetch_done; drives on the falling edge.
`timescale 1ns/1ps
module mir_store_model (
   input wire logic clock,
   input wire logic fetch_req,
   input wire logic [15:0] fetch_hm,
   input wire logic [15:0] fetch_md,
   input wire logic [15:0] fetch_year,
   input wire logic [7:0] delay,
   input wire logic found,
   output logic fetch_done,
   output logic fetch_found,
   output logic [15:0] fetch_quality,
   output logic [31:0] fetch_real,
   output logic [31:0] fetch_reactive,
   output logic [31:0] fetch_apparent,
   output logic [31:0] fetch_pf
);
   logic [7:0] waited;
   wire logic [47:0] ts = {fetch_year, fetch_md, fetch_hm};
   // One driver only; the reset cycles settle both to zero
   always @(negedge clock) begin
      fetch_done <= fetch_req && !fetch_done && waited == delay;
      waited <= (fetch_req && !fetch_done) ? waited + 8'h01 : 8'h00;
   end
   // Record lines carry the inverse outside the answer cycle
   assign fetch_found = fetch_done ? found : !found;
   assign fetch_quality = fetch_done ? 16'h0000 : 16'hffff;
   assign fetch_real = fetch_done ? ts[47:16] : ~ts[47:16];
   assign fetch_reactive = fetch_done ? ts[31:0] : ~ts[31:0];
   assign fetch_apparent = {ts[15:0], ts[47:32]} ^ {32{!fetch_done}};
   assign fetch_pf = fetch_done ? ~ts[31:0] : ts[31:0];
endmodule : mir_store_model

// file: tb_top.sv
// Self-checking bench for mir_regs with the storage engine model.
// Assumes single-word register strobes driven on the falling edge.
`timescale 1ns/1ps
module tb_top;
   localparam logic [47:0] BAD [6] = '{48'h07e8_0101_1800,
      48'h07e8_0101_003c, 48'h07e8_0d01_0000, 48'h07e8_0001_0000,
      48'h07e8_0100_0000, 48'h07e8_0120_0000};
   logic clock, sys_rst, reg_wr, reg_rd, clock_load, range_load, found;
   logic reg_hit, fetch_req, fetch_done, fetch_found;
   logic [7:0] delay;
   logic [15:0] reg_addr, reg_wdata, reg_rdata, fetch_quality;
   logic [15:0] fetch_hm, fetch_md, fetch_year;
   logic [159:0] ld;
   logic [31:0] fetch_real, fetch_reactive, fetch_apparent, fetch_pf;
   logic [31:0] keep [4];
   logic [31:0] lv [4];
   int errors, n_checks, seed, k;
   mir_regs mir_regs_inst (.clock, .sys_rst, .reg_wr, .reg_rd, .reg_addr,
      .reg_wdata, .reg_rdata, .reg_hit, .clock_load, .clock_hm_in(ld[159:144]),
      .clock_sec_in(ld[143:128]), .clock_md_in(ld[127:112]),
      .clock_year_in(ld[111:96]), .range_load, .oldest_hm_in(ld[95:80]),
      .oldest_md_in(ld[79:64]), .oldest_year_in(ld[63:48]),
      .newest_hm_in(ld[47:32]), .newest_md_in(ld[31:16]),
      .newest_year_in(ld[15:0]), .fetch_req, .fetch_hm, .fetch_md,
      .fetch_year, .fetch_done, .fetch_found, .fetch_quality, .fetch_real,
      .fetch_reactive, .fetch_apparent, .fetch_pf, .live_freq_a(lv[0]),
      .live_volt_an(lv[1]), .live_volt_bn(lv[2]), .live_volt_cn(lv[3]));
   mir_store_model mir_store_model_inst (.clock, .fetch_req, .fetch_hm,
      .fetch_md, .fetch_year, .delay, .found, .fetch_done, .fetch_found,
      .fetch_quality, .fetch_real, .fetch_reactive, .fetch_apparent,
      .fetch_pf);
   function automatic logic [31:0] f_rec(input logic [47:0] ts, input int i);
      case (i)
         0: return ts[47:16];
         1: return ts[31:0];
         2: return {ts[15:0], ts[47:32]};
         default: return ~ts[31:0];
      endcase
   endfunction : f_rec
   function automatic logic [47:0] f_ts(input logic [31:0] r);
      return {r[31:16], 8'(r[15:8] % 12 + 1), 8'(r[7:0] % 31 + 1),
         8'(r[12:8] % 24), 8'(r[7:2] % 60)};
   endfunction : f_ts
   function automatic logic [15:0] f_lva(input int i);
      return 16'((i < 2 ? 'h162 : 'h168 + i / 2 * 2) + i % 2);
   endfunction : f_lva
   function automatic logic [15:0] f_rst(input logic [15:0] a);
      if (a == mir_pkg::ADDR_VALIDITY) return mir_pkg::QUAL_INVALID;
      if (a inside {16'h0038, 16'h003b, 16'h003e, 16'h0041}) return 16'h0101;
      return 16'h0000;
   endfunction : f_rst
   task automatic test_done;
      if (errors == 0 && n_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : test_done
   task automatic chk(input string what, input logic [31:0] exp, got);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // Every strobe is assigned once per step so back-to-back ops stay legal
   task automatic op(input logic w, r, input logic [15:0] a, d);
      {reg_wr, reg_rd, reg_addr, reg_wdata} = {w, r, a, d};
      @(negedge clock);
   endtask : op
   task automatic rd(input logic [15:0] a, exp, input string what);
      op(1'b0, 1'b1, a, 16'h0000);
      chk(what, exp, reg_rdata);
   endtask : rd
   task automatic idle(input int n);
      {reg_wr, reg_rd} = 2'b00;
      repeat (n) @(negedge clock);
   endtask : idle
   task automatic load(input logic [47:0] ts, input logic [15:0] cmd,
      input logic [7:0] dly, input logic fnd, bad);
      logic seen;
      int j;
      {seen, delay, found} = {1'b0, dly, fnd};
      op(1'b1, 1'b0, mir_pkg::ADDR_SEL_HM, ts[15:0]);
      op(1'b1, 1'b0, mir_pkg::ADDR_SEL_MD, ts[31:16]);
      op(1'b1, 1'b0, mir_pkg::ADDR_SEL_YEAR, ts[47:32]);
      op(1'b1, 1'b0, mir_pkg::ADDR_HANDSHAKE, cmd);
      rd(mir_pkg::ADDR_HANDSHAKE, mir_pkg::HS_LOAD, "flag");
      if (dly > 8'd4) begin
         op(1'b1, 1'b0, mir_pkg::ADDR_SEL_HM, ~ts[15:0]);
         op(1'b1, 1'b0, mir_pkg::ADDR_HANDSHAKE, 16'h0001);
         rd(mir_pkg::ADDR_SEL_HM, ts[15:0], "frozen selection");
         rd(mir_pkg::ADDR_HANDSHAKE, mir_pkg::HS_LOAD, "busy flag");
      end
      idle(0);
      for (j = 0; j < 300 && !bad && !seen; j++) begin
         @(posedge clock);
         seen = fetch_done;
      end
      if (!bad) chk("fetch answer", 1'b1, seen);
      @(negedge clock);
      rd(mir_pkg::ADDR_HANDSHAKE, (bad || !fnd) ? mir_pkg::HS_INVALID :
         mir_pkg::HS_READY, "flag result");
      chk("fetch request", 1'b0, fetch_req);
      if (!bad) rd(mir_pkg::ADDR_VALIDITY, fnd ? 16'h0000 : 16'h0008,
         "quality");
      if (!bad && fnd) for (j = 0; j < 4; j++) keep[j] = f_rec(ts, j);
      for (j = 0; j < 8; j++) rd(16'(16'h0064 + j), j[0] ? keep[j / 2][15:0] :
         keep[j / 2][31:16], "stored record");
      idle(1);
   endtask : load
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   // Twenty thousand cycles, far beyond the few hundred cycles the tests need
   initial begin
      #200000;
      errors++;
      test_done();
   end
   initial begin
      {errors, n_checks, seed, sys_rst, delay, found} = {32'd0, 32'd0, 32'd81,
         1'b1, 8'h00, 1'b1};
      {reg_wr, reg_rd, clock_load, range_load, reg_addr, reg_wdata} = 36'h0;
      ld = 160'h0;
      for (k = 0; k < 4; k++) keep[k] = 32'h0000_0000;
      for (k = 0; k < 4; k++) lv[k] = $random(seed);
      repeat (16) @(negedge clock);
      sys_rst = 1'b0;
      for (k = 0; k < 17; k++) op(1'b1, 1'b0, k < 9 ? 16'(16'h0063 + k) :
         f_lva(k - 9), 16'($random(seed)));
      for (k = 16'h0036; k <= 16'h006b; k++)
         rd(16'(k), f_rst(16'(k)), "reset value");
      for (k = 0; k < 8; k++) rd(f_lva(k), k[0] ? lv[k / 2][15:0] :
         lv[k / 2][31:16], "live value");
      rd(16'h0050, 16'h0000, "unmapped read");
      chk("hit flag", 1'b0, reg_hit);
      for (k = 16'h0036; k <= 16'h0042; k++) begin
         ld[15:0] = 16'($random(seed));
         op(1'b1, 1'b0, 16'(k), ld[15:0]);
         rd(16'(k), ld[15:0], "rw register");
      end
      idle(0);
      ld = {$random(seed), $random(seed), 96'h0000_0101_0000_173b_0c1f_ffff};
      {clock_load, range_load} = 2'b11;
      @(negedge clock);
      {clock_load, range_load} = 2'b00;
      for (k = 0; k < 10; k++)
         rd(16'(16'h0036 + k), ld[159 - 16 * k -: 16], "loaded time");
      load(f_ts($random(seed)), 16'h0001, 8'd0, 1'b1, 1'b0);
      load(f_ts($random(seed)), 16'h8001, 8'd20, 1'b1, 1'b0);
      load(f_ts($random(seed)), 16'h0001, 8'd3, 1'b0, 1'b0);
      for (k = 0; k < 6; k++) load(BAD[k], 16'h0001, 8'd0, 1'b1, 1'b1);
      for (k = 0; k < 4; k++) load(f_ts($random(seed)), 16'h0001,
         8'(k * 3), 1'b1, 1'b0);
      test_done();
   end
endmodule : tb_top
